// ---- core/edo_host_pkg.sv ----
package edo_host_pkg;
	localparam int ADDR_W = 20;
	localparam int HALF_W = 10;
	localparam int DATA_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int CNT_W = 4;
	localparam int SYNC_DEPTH = 3;

	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;

	// access, precharge and row strobe low times
	localparam int T_RAC_NS = 50;
	localparam int T_CAC_NS = 13;
	localparam int T_RP_NS = 30;
	localparam int T_RAS_NS = 50;

	// refresh budget
	localparam int REF_WINDOW_MS = 16;
	localparam int REF_ROWS = 1024;

	function automatic int least_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ROW_CYC = least_cyc(T_RAC_NS - T_CAC_NS);
	localparam int CAS_CYC = least_cyc(T_CAC_NS);
	localparam int RP_CYC = least_cyc(T_RP_NS);
	localparam int RAS_CYC = least_cyc(T_RAS_NS);
	// longest spacing per row, rounded down
	localparam int REF_INTERVAL_CYC = REF_WINDOW_MS * 1000 * CLK_MHZ / REF_ROWS;

	localparam logic [HALF_W-1:0] ADDR_RST = 10'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [LANES-1:0] LANES_OFF = 2'h3;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ROW_SET = 3'h1,
		S_ROW = 3'h3,
		S_COL_SET = 3'h7,
		S_CAS = 3'h6,
		S_PRE = 3'h4,
		S_REF_CAS = 3'h2,
		S_REF_RAS = 3'h5
	} state_t;
endpackage

// ---- core/refresh_pacer.sv ----
`timescale 1ns/1ps
module refresh_pacer #(
	parameter int INTERVAL = edo_host_pkg::REF_INTERVAL_CYC
) (
	// clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// refresh handshake
	input wire logic ack_in,
	output logic req_out
);
	import edo_host_pkg::*;

	localparam int W = $clog2(INTERVAL + 1);

	if (INTERVAL < 2) begin : g_chk
		$error("refresh interval too short");
	end

	logic [W-1:0] cnt_r;
	logic tick;

	assign tick = (cnt_r == W'(INTERVAL - 1));

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cnt_r <= '0;
			req_out <= 1'b0;
		end else if (ce_in) begin
			cnt_r <= tick ? '0 : cnt_r + 1'b1;
			// new tick wins over ack
			req_out <= tick | (req_out & ~ack_in); // [R15]
		end
	end

	AST_PACE_SET: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(tick && ce_in) |=> req_out) // [R15]
		else $error("refresh tick lost");
endmodule

// ---- core/edo_host.sv ----
// Summary of operation
// R1: device stores 1,048,576 words of sixteen bits each.
// R2: row then column share the ten mux_addr lines.
// R3: device latches row when row strobe falls.
// R4: device latches column when internal column strobe falls.
// R5: internal strobe: first byte strobe falling to last rising.
// R6: low byte strobe governs data bits 0 to 7.
// R7: high byte strobe governs data bits 8 to 15.
// R8: byte output drive needs its strobe, row strobe, we, oe.
// R9: low-only read drives low byte, upper stays high impedance.
// R10: low-only write stores low byte, upper byte untouched.
// R11: early write: we low with strobes low; oe ignored.
// R12: all write cycles may be single-byte writes.
// R13: all read cycles may be single-byte reads.
// R14: column-first refresh: a byte strobe low when row strobe falls.
// R15: controller issues 1,024 row refreshes every 16 ms.
// R16: self refresh covers 1,024 rows within 128 ms internally.
// R17: device supports row-only, column-first and hidden refresh.
// R18: open row allows page access to any of 1,024 columns.
// R19: column-first refresh uses internal row counter, outputs off.
// R20: row-only, read and write cycles refresh the presented row.
// R21: write starts at later of strobe and we falling.
// R22: page read data held until next column strobe fall.
// R23: all strobes high means standby, data pins off.
// R24: word read needs all strobes low, we high, oe low.
`timescale 1ns/1ps
module edo_host #(
	parameter int REF_INTERVAL = edo_host_pkg::REF_INTERVAL_CYC
) (
	// clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// request port
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire logic [edo_host_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic [edo_host_pkg::DATA_W-1:0] req_wdata_in,
	input wire logic [edo_host_pkg::LANES-1:0] req_byte_en_in,
	// read answer
	output logic rd_valid_out,
	output logic [edo_host_pkg::DATA_W-1:0] rd_data_out,
	// memory pins
	output logic ras_n_out,
	output logic low_byte_col_strobe_n_out,
	output logic high_byte_col_strobe_n_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic [edo_host_pkg::HALF_W-1:0] mux_addr_out,
	input wire logic [edo_host_pkg::DATA_W-1:0] data_pins_in,
	output logic [edo_host_pkg::DATA_W-1:0] data_pins_out,
	output logic [edo_host_pkg::LANES-1:0] data_pins_oe_n_out
);
	import edo_host_pkg::*;

	// byte enables to active-low lane strobes, none means whole word
	function automatic logic [LANES-1:0] lane_n(input logic [LANES-1:0] be);
		return (be == '0) ? '0 : ~be;
	endfunction

	state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [ADDR_W-1:0] addr_r;
	logic [LANES-1:0] lanes_n_r;
	logic wr_r;
	logic ref_cyc_r;
	logic ras_n_r;
	logic [LANES-1:0] cas_n_r;
	logic [LANES-1:0] drv_n_r;
	logic [DATA_W-1:0] sync1_r, sync2_r, sync3_r;
	logic ref_req;
	logic ref_ack;
	logic cnt_done;
	logic take;
	logic rd_stable;
	logic rd_capture;

	refresh_pacer #(.INTERVAL(REF_INTERVAL)) u_pacer (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.ack_in(ref_ack),
		.req_out(ref_req)
	);

	assign cnt_done = (cnt_r == '0);
	assign req_ready_out = (state_r == S_IDLE) && !ref_req && ce_in;
	assign take = req_valid_in && req_ready_out;
	assign ref_ack = ce_in && (state_r == S_IDLE) && ref_req; // [R15]
	// pin data counts once second and third stage agree
	assign rd_stable = (sync2_r == sync3_r);
	assign rd_capture = ce_in && (state_r == S_CAS) && cnt_done &&
		!wr_r && rd_stable;

	assign ras_n_out = ras_n_r;
	assign low_byte_col_strobe_n_out = cas_n_r[0];
	assign high_byte_col_strobe_n_out = cas_n_r[1];
	assign data_pins_oe_n_out = drv_n_r;

	// per-lane write data
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		always_ff @(posedge sys_clk_in) begin
			if (srst_in) begin
				data_pins_out[i*LANE_W +: LANE_W] <= '0;
			end else if (ce_in && take) begin
				data_pins_out[i*LANE_W +: LANE_W] <=
					req_wdata_in[i*LANE_W +: LANE_W];
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sync1_r <= DATA_RST;
			sync2_r <= DATA_RST;
			sync3_r <= DATA_RST;
		end else if (ce_in) begin
			sync1_r <= data_pins_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= DATA_RST;
		end else if (ce_in) begin
			rd_valid_out <= rd_capture;
			if (rd_capture) begin
				rd_data_out <= sync3_r;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			state_r <= S_IDLE;
			cnt_r <= '0;
			addr_r <= '0;
			lanes_n_r <= LANES_OFF;
			wr_r <= 1'b0;
			ref_cyc_r <= 1'b0;
			ras_n_r <= 1'b1;
			cas_n_r <= LANES_OFF;
			drv_n_r <= LANES_OFF;
			we_n_out <= 1'b1;
			oe_n_out <= 1'b1;
			mux_addr_out <= ADDR_RST;
		end else if (ce_in) begin
			if (!cnt_done) begin
				cnt_r <= cnt_r - 1'b1;
			end
			case (state_r)
				S_IDLE: begin
					if (ref_req) begin
						// strobes low before row strobe falls
						cas_n_r <= '0; // [R14]
						ref_cyc_r <= 1'b1;
						state_r <= S_REF_CAS;
					end else if (take) begin
						addr_r <= req_addr_in;
						wr_r <= req_write_in;
						lanes_n_r <= lane_n(req_byte_en_in);
						ref_cyc_r <= 1'b0;
						mux_addr_out <= req_addr_in[ADDR_W-1:HALF_W]; // [R2]
						state_r <= S_ROW_SET;
					end
				end
				S_ROW_SET: begin
					ras_n_r <= 1'b0;
					cnt_r <= CNT_W'(ROW_CYC - 1);
					state_r <= S_ROW;
				end
				S_ROW: begin
					if (cnt_done) begin
						mux_addr_out <= addr_r[HALF_W-1:0]; // [R2]
						// we low ahead of the strobes
						we_n_out <= ~wr_r; // [R11]
						oe_n_out <= wr_r;
						drv_n_r <= wr_r ? lanes_n_r : LANES_OFF; // [R12]
						state_r <= S_COL_SET;
					end
				end
				S_COL_SET: begin
					cas_n_r <= lanes_n_r; // [R13]
					cnt_r <= CNT_W'(CAS_CYC + SYNC_DEPTH - 1);
					state_r <= S_CAS;
				end
				S_CAS: begin
					if (cnt_done && (wr_r || rd_stable)) begin
						ras_n_r <= 1'b1;
						cas_n_r <= LANES_OFF;
						we_n_out <= 1'b1;
						oe_n_out <= 1'b1;
						drv_n_r <= LANES_OFF;
						cnt_r <= CNT_W'(RP_CYC - 1);
						state_r <= S_PRE;
					end
				end
				S_REF_CAS: begin
					ras_n_r <= 1'b0;
					cnt_r <= CNT_W'(RAS_CYC - 1);
					state_r <= S_REF_RAS;
				end
				S_REF_RAS: begin
					if (cnt_done) begin
						ras_n_r <= 1'b1;
						cas_n_r <= LANES_OFF;
						cnt_r <= CNT_W'(RP_CYC - 1);
						state_r <= S_PRE;
					end
				end
				S_PRE: begin
					if (cnt_done) begin
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in || !ce_in);

	AST_REF_CAS_FIRST: assert property ( // [R14]
		($fell(ras_n_out) && ref_cyc_r) |->
		!(low_byte_col_strobe_n_out && high_byte_col_strobe_n_out))
		else $error("refresh without a low byte strobe");
	AST_ACC_CAS_HIGH: assert property ( // [R14]
		($fell(ras_n_out) && !ref_cyc_r) |->
		(low_byte_col_strobe_n_out && high_byte_col_strobe_n_out))
		else $error("access opened with a strobe low");
	AST_ROW_ADDR: assert property ( // [R2]
		($fell(ras_n_out) && !ref_cyc_r) |->
		(mux_addr_out == addr_r[ADDR_W-1:HALF_W]))
		else $error("row half wrong at row strobe");
	AST_COL_ADDR: assert property ( // [R2]
		($fell(low_byte_col_strobe_n_out & high_byte_col_strobe_n_out)
		&& !ref_cyc_r) |-> (mux_addr_out == addr_r[HALF_W-1:0]))
		else $error("column half wrong at column strobe");
	AST_EARLY_WE: assert property ( // [R11]
		($fell(low_byte_col_strobe_n_out & high_byte_col_strobe_n_out)
		&& !ref_cyc_r && wr_r) |->
		(!we_n_out && $past(!we_n_out) && oe_n_out))
		else $error("write enable not early");
	AST_DRIVE_WRITE_ONLY: assert property ( // [R11]
		(data_pins_oe_n_out != LANES_OFF) |-> (!we_n_out && !ras_n_out))
		else $error("data driven outside a write");
	AST_REF_SERVED: assert property ( // [R15]
		$rose(ref_req) |-> ##[0:60] ref_ack)
		else $error("refresh not served in time");
	AST_PRECHARGE: assert property (
		$rose(ras_n_out) |-> ras_n_out [*3])
		else $error("precharge too short");
	AST_RD_PULSE: assert property (
		rd_valid_out |=> !rd_valid_out)
		else $error("read answer longer than a cycle");

	COV_WRITE: cover property (take && req_write_in);
	COV_READ_DONE: cover property (rd_valid_out);
	COV_BYTE_READ: cover property ($fell(low_byte_col_strobe_n_out)
		&& high_byte_col_strobe_n_out && we_n_out);
	COV_REFRESH: cover property ($fell(ras_n_out) && ref_cyc_r);
endmodule

// ---- tb/edo_mem_model.sv ----
`timescale 1ns/1ps
module edo_mem_model
	import edo_host_pkg::*;
(
	// strobes and address
	input wire logic ras_n_in,
	input wire logic low_n_in,
	input wire logic high_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic [edo_host_pkg::HALF_W-1:0] mux_addr_in,
	// data pins
	input wire logic [edo_host_pkg::DATA_W-1:0] dq_in,
	output logic [edo_host_pkg::DATA_W-1:0] dq_out,
	output logic [edo_host_pkg::LANES-1:0] dq_drv_out,
	// observation
	output logic [edo_host_pkg::HALF_W-1:0] row_out,
	output logic [edo_host_pkg::HALF_W-1:0] col_out,
	output int ref_count_out
);
	import edo_host_pkg::*;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	wire cas_n = low_n_in & high_n_in;
	wire rd = !ras_n_in && !cas_n && we_n_in && !oe_n_in;
	wire [ADDR_W-1:0] loc = {row_out, mux_addr_in};
	initial begin
		row_out = '0;
		col_out = '0;
		dq_out = '0;
		ref_count_out = 0;
	end
	always @(negedge ras_n_in) begin
		if (!cas_n)
			ref_count_out++;
		else
			row_out = mux_addr_in;
	end
	always @(negedge cas_n) begin
		if (!ras_n_in) begin
			col_out = mux_addr_in;
			dq_out = mem.exists(loc) ? mem[loc] : '0;
		end
	end
	// write starts at the later fall of strobe and we
	always @(negedge low_n_in or negedge high_n_in or negedge we_n_in) begin
		if (!ras_n_in && !we_n_in) begin
			if (!low_n_in)
				mem[loc][7:0] = dq_in[7:0];
			if (!high_n_in)
				mem[loc][15:8] = dq_in[15:8];
		end
	end
	assign dq_drv_out[0] = rd && !low_n_in;
	assign dq_drv_out[1] = rd && !high_n_in;
endmodule

// ---- tb/edo_host_tb.sv ----
`timescale 1ns/1ps
module edo_host_tb;
	import edo_host_pkg::*;
	localparam int REF_I = 64;
	logic sys_clk_in = 0, srst_in = 1, ce_in = 1;
	logic req_valid_in = 0, req_write_in = 0;
	logic [ADDR_W-1:0] req_addr_in = '0;
	logic [DATA_W-1:0] req_wdata_in = '0, last_r = '0, rdat;
	logic [LANES-1:0] req_byte_en_in = '0;
	logic req_ready_out, rd_valid_out, ras_n_out, we_n_out, oe_n_out;
	logic low_n, high_n;
	logic [DATA_W-1:0] rd_data_out, data_pins_out, dq_m;
	wire [DATA_W-1:0] data_pins_in;
	logic [HALF_W-1:0] mux_addr_out, row_m, col_m;
	logic [LANES-1:0] data_pins_oe_n_out, drv_m;
	int ref_m, fail_count = 0, checks = 0, cyc = 0;

	edo_host #(.REF_INTERVAL(REF_I)) DUT (.sys_clk_in(sys_clk_in),
		.srst_in(srst_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
		.req_ready_out(req_ready_out), .req_write_in(req_write_in),
		.req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_byte_en_in(req_byte_en_in), .rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out), .ras_n_out(ras_n_out),
		.low_byte_col_strobe_n_out(low_n), .high_byte_col_strobe_n_out(high_n),
		.we_n_out(we_n_out), .oe_n_out(oe_n_out), .mux_addr_out(mux_addr_out),
		.data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
		.data_pins_oe_n_out(data_pins_oe_n_out));
	edo_mem_model mem_i (.ras_n_in(ras_n_out), .low_n_in(low_n),
		.high_n_in(high_n), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
		.mux_addr_in(mux_addr_out), .dq_in(data_pins_in), .dq_out(dq_m),
		.dq_drv_out(drv_m), .row_out(row_m), .col_out(col_m),
		.ref_count_out(ref_m));

	// undriven lane shows the inverse of its last driven value
	for (genvar b = 0; b < LANES; b++) begin : g_pin
		assign data_pins_in[b*8 +: 8] = !data_pins_oe_n_out[b] ?
			data_pins_out[b*8 +: 8] : drv_m[b] ? dq_m[b*8 +: 8] : ~last_r[b*8 +: 8];
		always @(posedge sys_clk_in) begin
			if (!data_pins_oe_n_out[b] || drv_m[b])
				last_r[b*8 +: 8] <= data_pins_in[b*8 +: 8];
		end
	end

	always #5 sys_clk_in = ~sys_clk_in;

	task automatic end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [LANES-1:0] be);
		int n = 0;
		req_valid_in <= 1'b1;
		req_write_in <= w;
		req_addr_in <= a;
		req_wdata_in <= d;
		req_byte_en_in <= be;
		@(posedge sys_clk_in);
		while (req_ready_out !== 1'b1) @(posedge sys_clk_in);
		req_valid_in <= 1'b0;
		@(posedge sys_clk_in);
		while (!w && rd_valid_out !== 1'b1 && n < 200) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 200)
			fail_count++;
		rdat = rd_data_out;
		while (req_ready_out !== 1'b1 && n < 400) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 400)
			fail_count++;
	endtask

	task automatic t_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		xfer(1'b1, a, d, 2'h3);
		chk({6'h0, row_m}, {6'h0, a[19:10]});
		chk({6'h0, col_m}, {6'h0, a[9:0]});
		xfer(1'b0, a, 16'h0000, 2'h3);
		chk(rdat, d);
	endtask

	task automatic t_bytes();
		xfer(1'b1, 20'h2a5c3, 16'h1111, 2'h3);
		xfer(1'b1, 20'h2a5c3, 16'h77ab, 2'h1);
		xfer(1'b1, 20'h2a5c3, 16'hcd66, 2'h2);
		xfer(1'b0, 20'h2a5c3, 16'h0000, 2'h3);
		chk(rdat, 16'hcdab);
		xfer(1'b0, 20'h2a5c3, 16'h0000, 2'h1);
		chk({8'h00, rdat[7:0]}, 16'h00ab);
		xfer(1'b0, 20'h2a5c3, 16'h0000, 2'h2);
		chk({rdat[15:8], 8'h00}, 16'hcd00);
		xfer(1'b1, 20'h00401, 16'h5a3c, 2'h0);
		xfer(1'b0, 20'h00401, 16'h0000, 2'h3);
		chk(rdat, 16'h5a3c);
	endtask

	task automatic t_refresh();
		int r0 = ref_m;
		repeat (10 * REF_I) @(posedge sys_clk_in);
		chk({15'h0, (ref_m - r0) >= 9}, 16'h0001);
	endtask

	task automatic t_ce();
		// freeze from idle so the pins must rest in standby
		while (req_ready_out !== 1'b1) @(posedge sys_clk_in);
		ce_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		chk({15'h0, req_ready_out}, 16'h0000);
		chk({13'h0, ras_n_out, low_n, high_n}, 16'h0007);
		chk({14'h0, data_pins_oe_n_out}, 16'h0003);
		ce_in <= 1'b1;
		@(posedge sys_clk_in);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		@(posedge sys_clk_in);
		t_word(20'h00000, 16'ha53c);
		t_word(20'hfffff, 16'h3cc3);
		t_bytes();
		t_refresh();
		t_ce();
		t_word(20'h81234, 16'h0ff0);
		end_sim();
	end
endmodule
